// File: global_memory_and_bus_hold.sv
// Global memory arbitration and bus hold sequencer
`timescale 1ns/100ps
`include "gmbh_params.svh"

module global_memory_and_bus_hold (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,

    // Core data-space access
    input  gmbh_pkg::data_acc_t          data_acc,
    output logic                         data_wait,
    output logic [15:0]                  reg_rdata,
    output logic                         reg_rvalid,

    // Core execution status and control
    input  gmbh_pkg::core_status_t       core_status,
    input  wire logic                    set_release_mode_instr,
    input  wire logic                    clear_release_mode_instr,
    output logic                         core_halt,
    output logic                         irq_blocked,
    output logic                         release_mode_bit,

    // Global memory pins
    output logic                         data_space_strobe,
    output logic                         global_bus_request_n,
    input  wire logic                    ready,

    // Bus release pins
    input  wire logic                    bus_release_req_n,
    output logic                         bus_release_ack_n,

    // External bus output enables, low while driving
    output logic                         addr_oe_n,
    output logic                         data_oe_n,
    output logic                         strobe_oe_n,

    // Serial transmit pins
    input  gmbh_pkg::serial_tx_t         serial_tx_in,
    output gmbh_pkg::serial_tx_t         serial_tx_out,
    output logic                         serial_tx_oe_n
);

    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        gmbh_pkg::hold_state_t hs;
        logic [1:0]            mc_cnt;
        logic                  ack_n;
        logic                  float_bus;
        logic                  mode;
        logic                  held_mode;
        logic [7:0]            alloc;
        logic [15:0]           rdata;
        logic                  rvalid;
        gmbh_pkg::serial_tx_t  serial;
    } main_state_t;

    main_state_t       state_ff;
    main_state_t       nxt_state;
    gmbh_pkg::phase_t  phase;
    logic              is_global;
    logic              reg_hit;
    logic              req_active;
    logic              accept;
    logic              in_release;
    logic              needs_ext;

    // ****************************************************
    // Submodules
    // ****************************************************
    quarter_phase_gen u_phase (
        .core_clk (core_clk),
        .rst      (rst),
        .phase    (phase)
    );

    global_region_decode u_decode (
        .alloc     (state_ff.alloc),
        .addr      (data_acc.addr),
        .is_global (is_global)
    );

    // ****************************************************
    // Helper terms
    // ****************************************************

    // Allocation register decode on the internal data bus
    assign reg_hit = data_acc.req && (data_acc.addr == `ALLOC_ADDR);

    // Release request seen only on the Q3 sample, never latched
    assign req_active = phase.q3_start && !bus_release_req_n;

    // Core wants the external buses this cycle
    assign needs_ext = core_status.exec_external
                     | core_status.ext_access_req
                     | core_status.branch_external;

    // Point at which the buses may be handed over
    always_comb begin
        if (state_ff.mode) begin
            // Whole instruction and whole repeat block first
            accept = core_status.instr_end && !core_status.repeat_busy;
        end else begin
            // Mode zero gives way at instruction end, after a bus cycle in a repeat, or when not executing or accessing externally
            accept = core_status.instr_end
                   | (core_status.repeat_busy & core_status.bus_cycle_end)
                   | !(core_status.exec_external | core_status.ext_access_req);
        end
    end

    // Any state in which the buses are not the core's
    assign in_release = (state_ff.hs == gmbh_pkg::HS_ENTER)
                     || (state_ff.hs == gmbh_pkg::HS_HELD)
                     || (state_ff.hs == gmbh_pkg::HS_LEAVE);

    // ****************************************************
    // Next-state logic
    // ****************************************************
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.rvalid = 1'b0;

        // Allocation register write, low byte only
        if (reg_hit && data_acc.wr) begin
            nxt_state.alloc = data_acc.wdata[7:0];
        end

        // Read returns ones above the eight real bits
        if (reg_hit && !data_acc.wr) begin
            nxt_state.rdata  = {`ALLOC_HI_FILL, state_ff.alloc};
            nxt_state.rvalid = 1'b1;
        end

        // Mode bit from its two instructions
        if (set_release_mode_instr) begin
            nxt_state.mode = 1'b1;
        end else if (clear_release_mode_instr) begin
            nxt_state.mode = 1'b0;
        end

        // Serial outputs pass through, untouched by release
        nxt_state.serial = serial_tx_in;

        // Hold sequencer
        unique case (state_ff.hs)
            gmbh_pkg::HS_RUN: begin
                if (req_active) begin
                    nxt_state.hs = gmbh_pkg::HS_WAIT;
                end
            end
            gmbh_pkg::HS_WAIT: begin
                // Request dropped before hand-over: nothing kept
                if (phase.q3_start && bus_release_req_n) begin
                    nxt_state.hs = gmbh_pkg::HS_RUN;
                end else if (accept) begin
                    nxt_state.hs        = gmbh_pkg::HS_ENTER;
                    nxt_state.mc_cnt    = 2'h0;
                    nxt_state.held_mode = state_ff.mode;
                end
            end
            gmbh_pkg::HS_ENTER: begin
                // Count machine cycles up to the float point
                if (phase.mc_start) begin
                    if (state_ff.mc_cnt == `ENTER_MC - 2'h1) begin
                        nxt_state.hs        = gmbh_pkg::HS_HELD;
                        nxt_state.float_bus = 1'b1;
                        nxt_state.ack_n     = 1'b0;
                    end else begin
                        nxt_state.mc_cnt = state_ff.mc_cnt + 2'h1;
                    end
                end
            end
            gmbh_pkg::HS_HELD: begin
                // Acknowledge rises at the first Q3 sample that sees the request high
                if (phase.q3_start && bus_release_req_n) begin
                    nxt_state.hs     = gmbh_pkg::HS_LEAVE;
                    nxt_state.ack_n  = 1'b1;
                    nxt_state.mc_cnt = 2'h0;
                end
            end
            gmbh_pkg::HS_LEAVE: begin
                if (phase.mc_start) begin
                    if (state_ff.mc_cnt == `LEAVE_MC - 2'h1) begin
                        nxt_state.hs        = gmbh_pkg::HS_RUN;
                        nxt_state.float_bus = 1'b0;
                    end else begin
                        nxt_state.mc_cnt = state_ff.mc_cnt + 2'h1;
                    end
                end
            end
            default: begin
                // Illegal code recovers to a running, driven bus
                nxt_state.hs        = gmbh_pkg::HS_RUN;
                nxt_state.float_bus = 1'b0;
                nxt_state.ack_n     = 1'b1;
            end
        endcase
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff.hs        <= gmbh_pkg::HS_RUN;
            state_ff.mc_cnt    <= 2'h0;
            state_ff.ack_n     <= 1'b1;
            state_ff.float_bus <= 1'b0;
            state_ff.mode      <= `MODE_RST;
            state_ff.held_mode <= `MODE_RST;
            state_ff.alloc     <= `ALLOC_RST;
            state_ff.rdata     <= 16'h0000;
            state_ff.rvalid    <= 1'b0;
            state_ff.serial    <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************************
    // Global memory pins
    // ****************************************************

    // Strobe and request share timing; neither fires when floated
    assign data_space_strobe    = data_acc.req && !state_ff.float_bus;
    assign global_bus_request_n = !(data_space_strobe && is_global);

    // Wait states until the arbiter grants; the register is internal
    assign data_wait = data_acc.req && is_global && !reg_hit && !ready;

    // ****************************************************
    // Core control
    // ****************************************************

    // Halt only; idle and interrupt state in the core are untouched
    always_comb begin
        if (!in_release) begin
            core_halt = 1'b0;
        end else if (state_ff.held_mode) begin
            core_halt = 1'b1;
        end else begin
            core_halt = needs_ext;
        end
    end

    // Interrupts held pending only in the halting mode
    assign irq_blocked = in_release && state_ff.held_mode;

    // ****************************************************
    // Pin drivers and status
    // ****************************************************
    assign bus_release_ack_n = state_ff.ack_n;
    assign addr_oe_n         = state_ff.float_bus;
    assign data_oe_n         = state_ff.float_bus;
    assign strobe_oe_n       = state_ff.float_bus;
    assign serial_tx_out     = state_ff.serial;
    assign serial_tx_oe_n    = 1'b0;
    assign release_mode_bit  = state_ff.mode;
    assign reg_rdata         = state_ff.rdata;
    assign reg_rvalid        = state_ff.rvalid;

endmodule : global_memory_and_bus_hold

// File: global_region_decode.sv
// Global data region decoder from the allocation value
`timescale 1ns/100ps
`include "gmbh_params.svh"

module global_region_decode (
    // Allocation value and address
    input  wire logic [7:0]  alloc,
    input  wire logic [15:0] addr,
    // Result
    output logic             is_global
);

    logic [7:0] bit_ok;

    // ****************************************************
    // Per-bit mask match on the high address byte
    // ****************************************************
    for (genvar i = 0; i < 8; i++) begin : g_match
        assign bit_ok[i] = ~alloc[i] | addr[`GLOB_LSB + i];
    end

    // Upper six bits clear means no global region at all
    assign is_global = (|alloc[`GLOB_EN_MSB:`GLOB_EN_LSB]) & (&bit_ok);

endmodule : global_region_decode

// File: gmbh_checker.sv
// Port assertions for the global memory and bus hold block
`timescale 1ns/100ps
`include "gmbh_params.svh"

module gmbh_checker (
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    // Core side
    input gmbh_pkg::data_acc_t    data_acc,
    input wire logic              data_wait,
    input wire logic [15:0]       reg_rdata,
    input wire logic              reg_rvalid,
    input gmbh_pkg::core_status_t core_status,
    input wire logic              set_release_mode_instr,
    input wire logic              clear_release_mode_instr,
    input wire logic              core_halt,
    input wire logic              irq_blocked,
    input wire logic              release_mode_bit,
    // Bus pins
    input wire logic              data_space_strobe,
    input wire logic              global_bus_request_n,
    input wire logic              ready,
    input wire logic              bus_release_req_n,
    input wire logic              bus_release_ack_n,
    input wire logic              addr_oe_n,
    input wire logic              data_oe_n,
    input wire logic              strobe_oe_n,
    // Serial pins
    input gmbh_pkg::serial_tx_t   serial_tx_in,
    input gmbh_pkg::serial_tx_t   serial_tx_out,
    input wire logic              serial_tx_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ********
    // Sequences
    // ********
    sequence s_rd5;
        data_acc.req && !data_acc.wr && data_acc.addr == `ALLOC_ADDR;
    endsequence
    sequence s_answer;
        reg_rvalid && reg_rdata[15:8] == `ALLOC_HI_FILL;
    endsequence
    // Acknowledge rises only after the request was seen high
    sequence s_leave;
        $rose(bus_release_ack_n) && $past(bus_release_req_n);
    endsequence

    // ********
    // Assertions
    // ********
    a_read_answer: assert property (s_rd5 |=> s_answer)
        else $error("location 5 read answer wrong");
    a_req_strobe: assert property (!global_bus_request_n |-> data_space_strobe && data_acc.req)
        else $error("bus request without strobe");
    a_wait_ready: assert property (!global_bus_request_n |-> data_wait == !ready)
        else $error("wait state not tied to ready");
    a_ack_floats: assert property ($fell(bus_release_ack_n) |-> addr_oe_n && data_oe_n && strobe_oe_n)
        else $error("acknowledge without float");
    a_floated_quiet: assert property (addr_oe_n |-> !data_space_strobe && global_bus_request_n)
        else $error("strobe while floated");
    a_serial_live: assert property (!$past(rst) |-> serial_tx_out == $past(serial_tx_in) && !serial_tx_oe_n)
        else $error("serial output disturbed");
    a_enter_late: assert property ($fell(bus_release_ack_n) |-> $past(bus_release_req_n, 16) == 1'b0)
        else $error("release entered too early");
    a_ack_holds: assert property (!bus_release_ack_n && !bus_release_req_n |=> !bus_release_ack_n)
        else $error("acknowledge dropped early");
    a_leave_valid: assert property (s_leave |-> addr_oe_n ##[1:16] !addr_oe_n)
        else $error("buses not back in time");
    a_mode_set: assert property (set_release_mode_instr |=> release_mode_bit)
        else $error("mode bit not set");
    a_mode_clear: assert property (clear_release_mode_instr && !set_release_mode_instr
        |=> !release_mode_bit)
        else $error("mode bit not cleared");
    a_halt_mode1: assert property ($fell(bus_release_ack_n) && release_mode_bit
        |-> core_halt && irq_blocked)
        else $error("mode one release not halting");
    a_stall_mode0: assert property (!bus_release_ack_n && !release_mode_bit
        && core_status.ext_access_req |-> core_halt)
        else $error("external need not stalled");
endmodule : gmbh_checker

bind global_memory_and_bus_hold gmbh_checker i_chk (.core_clk, .rst, .data_acc, .data_wait,
    .reg_rdata, .reg_rvalid, .core_status, .set_release_mode_instr, .clear_release_mode_instr,
    .core_halt, .irq_blocked, .release_mode_bit, .data_space_strobe, .global_bus_request_n,
    .ready, .bus_release_req_n, .bus_release_ack_n, .addr_oe_n, .data_oe_n, .strobe_oe_n,
    .serial_tx_in, .serial_tx_out, .serial_tx_oe_n);

// File: gmbh_params.svh
// Constants for the global memory and bus hold block
`ifndef GMBH_PARAMS_SVH
`define GMBH_PARAMS_SVH

// ****************************************************
// Register map
// ****************************************************
`define ALLOC_ADDR     16'h0005
`define ALLOC_RST      8'h00
`define ALLOC_HI_FILL  8'hFF
`define MODE_RST       1'b1

// ****************************************************
// Global region field
// ****************************************************
`define GLOB_MSB       15
`define GLOB_LSB       8
`define GLOB_EN_MSB    7
`define GLOB_EN_LSB    2

// ****************************************************
// Timing, in core clocks and machine cycles
// ****************************************************
`define QPH_CLKS       2'h2
`define QPH_Q1         2'h0
`define QPH_Q3         2'h2
`define ENTER_MC       2'h3
`define LEAVE_MC       2'h2

`endif

// File: gmbh_partner.sv
// Model of the arbiter and bus master sharing the block's buses
`timescale 1ns/100ps

module gmbh_partner (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Bench control
    input  wire logic       hold_go,
    input  wire logic [1:0] ready_lat,
    input  wire logic [3:0] hold_len,
    // Block pins
    input  wire logic       global_bus_request_n,
    input  wire logic       bus_release_ack_n,
    output logic            ready,
    output logic            bus_release_req_n
);
    logic [1:0] grant_cnt_ff;
    logic [3:0] keep_cnt_ff;
    logic       seen_ff;

    // Arbitration delay, restarted on every new request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            grant_cnt_ff <= 2'h0;
        end else if (global_bus_request_n) begin
            grant_cnt_ff <= 2'h0;
        end else if (grant_cnt_ff != ready_lat) begin
            grant_cnt_ff <= grant_cnt_ff + 2'h1;
        end
    end
    assign ready = !global_bus_request_n && grant_cnt_ff == ready_lat;

    // Request held until acknowledge seen, then kept a while
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_release_req_n <= 1'b1;
            seen_ff           <= 1'b0;
            keep_cnt_ff       <= 4'h0;
        end else if (hold_go) begin
            bus_release_req_n <= 1'b0;
            seen_ff           <= 1'b0;
            keep_cnt_ff       <= hold_len;
        end else if (seen_ff) begin
            if (keep_cnt_ff != 4'h0) begin
                keep_cnt_ff <= keep_cnt_ff - 4'h1;
            end else begin
                bus_release_req_n <= 1'b1;
                seen_ff           <= 1'b0;
            end
        end else if (!bus_release_req_n && !bus_release_ack_n) begin
            seen_ff <= 1'b1;
        end
    end
endmodule : gmbh_partner

// File: gmbh_pkg.sv
// Types shared by the global memory and bus hold block
package gmbh_pkg;

    // ****************************************************
    // Hold sequencer states
    // ****************************************************
    typedef enum logic [2:0] {
        HS_RUN,
        HS_WAIT,
        HS_ENTER,
        HS_HELD,
        HS_LEAVE
    } hold_state_t;

    // Data-space access from the core
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } data_acc_t;

    // Execution status from the core sequencer
    typedef struct packed {
        logic instr_end;
        logic repeat_busy;
        logic bus_cycle_end;
        logic exec_external;
        logic ext_access_req;
        logic branch_external;
    } core_status_t;

    // Quarter-phase timing
    typedef struct packed {
        logic [1:0] qph;
        logic       q3_start;
        logic       mc_start;
    } phase_t;

    // Serial transmit pins
    typedef struct packed {
        logic data;
        logic frame_sync;
    } serial_tx_t;

endpackage : gmbh_pkg

// File: quarter_phase_gen.sv
// Quarter-phase and machine-cycle timing generator
`timescale 1ns/100ps
`include "gmbh_params.svh"

module quarter_phase_gen (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Timing out
    output gmbh_pkg::phase_t phase
);

    typedef struct packed {
        logic [1:0] cnt;
        logic [1:0] qph;
    } qstate_t;

    qstate_t state_ff;
    qstate_t nxt_state;

    // ****************************************************
    // Divider: each quarter phase lasts a fixed clock count
    // ****************************************************
    always_comb begin
        nxt_state = state_ff;
        if (state_ff.cnt == `QPH_CLKS - 2'h1) begin
            nxt_state.cnt = 2'h0;
            nxt_state.qph = state_ff.qph + 2'h1;
        end else begin
            nxt_state.cnt = state_ff.cnt + 2'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Start-of-quarter pulses, one clock wide
    assign phase.qph      = state_ff.qph;
    assign phase.q3_start = (state_ff.cnt == 2'h0) && (state_ff.qph == `QPH_Q3);
    assign phase.mc_start = (state_ff.cnt == 2'h0) && (state_ff.qph == `QPH_Q1);

endmodule : quarter_phase_gen

// File: test_global_memory_and_bus_hold.sv
// Self-checking bench for the global memory and bus hold block
`timescale 1ns/100ps
`include "gmbh_params.svh"

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end

module test_global_memory_and_bus_hold;
    logic                   core_clk = 1'b0;
    logic                   rst = 1'b1;
    gmbh_pkg::data_acc_t    data_acc = '0;
    gmbh_pkg::core_status_t core_status = 6'h20;
    logic                   set_release_mode_instr = 1'b0;
    logic                   clear_release_mode_instr = 1'b0;
    gmbh_pkg::serial_tx_t   serial_tx_in = '0;
    logic                   hold_go = 1'b0;
    logic [1:0]             ready_lat = 2'h0;
    logic [3:0]             hold_len = 4'h0;
    logic                   data_wait, reg_rvalid, core_halt, irq_blocked, release_mode_bit;
    logic                   data_space_strobe, global_bus_request_n, ready;
    logic                   bus_release_req_n, bus_release_ack_n, serial_tx_oe_n;
    logic                   addr_oe_n, data_oe_n, strobe_oe_n;
    logic [15:0]            reg_rdata;
    gmbh_pkg::serial_tx_t   serial_tx_out;
    logic [7:0]             alloc_m = `ALLOC_RST;
    integer                 seed = 32'h73c0;
    int                     fail_count = 0;
    int                     n_compared = 0;

    // ********
    // Clock, block and far side
    // ********
    always #4 core_clk = ~core_clk;

    global_memory_and_bus_hold i_dut (.core_clk, .rst, .data_acc, .data_wait, .reg_rdata,
        .reg_rvalid, .core_status, .set_release_mode_instr, .clear_release_mode_instr,
        .core_halt, .irq_blocked, .release_mode_bit, .data_space_strobe, .global_bus_request_n,
        .ready, .bus_release_req_n, .bus_release_ack_n, .addr_oe_n, .data_oe_n, .strobe_oe_n,
        .serial_tx_in, .serial_tx_out, .serial_tx_oe_n);
    gmbh_partner i_far (.core_clk, .rst, .hold_go, .ready_lat, .hold_len,
        .global_bus_request_n, .bus_release_ack_n, .ready, .bus_release_req_n);

    // Serial traffic runs all the time, holds included
    always @(posedge core_clk) serial_tx_in <= 2'($random(seed));

    // ********
    // Expectations and helpers
    // ********
    function automatic logic exp_glob(input logic [7:0] g, input logic [15:0] a);
        return (g[7:2] != 6'h00) && ((a[15:8] & g) == g);
    endfunction : exp_glob

    // Picks a watched level by code so one wait loop serves all
    function automatic logic sig(input int c);
        return (c == 0) ? data_wait : (c == 1) ? bus_release_ack_n : addr_oe_n;
    endfunction : sig

    task automatic wait_lvl(input int c, input logic v, output int k);
        k = 0;
        while (sig(c) !== v && k < 64) begin
            @(posedge core_clk);
            #1;
            k++;
        end
    endtask : wait_lvl

    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        int k;
        @(posedge core_clk);
        ready_lat <= 2'($random(seed));
        data_acc  <= '{req: 1'b1, wr: w, addr: a, wdata: d};
        #1;
        `CHK(global_bus_request_n, !exp_glob(alloc_m, a))
        wait_lvl(0, 1'b0, k);
        `CHK(data_wait, 1'b0)
        @(posedge core_clk);
        data_acc.req <= 1'b0;
        #1;
        if (w && a == `ALLOC_ADDR) alloc_m = d[7:0];
        `CHK(reg_rvalid, !w && a == `ALLOC_ADDR)
        if (!w && a == `ALLOC_ADDR) `CHK(reg_rdata, {`ALLOC_HI_FILL, alloc_m})
    endtask : acc

    task automatic mode_pulse(input logic s, input logic c);
        @(posedge core_clk);
        set_release_mode_instr   <= s;
        clear_release_mode_instr <= c;
        @(posedge core_clk);
        set_release_mode_instr   <= 1'b0;
        clear_release_mode_instr <= 1'b0;
        #1;
        `CHK(release_mode_bit, s)
    endtask : mode_pulse

    // Whole release: optional refusal, checks while held, return
    task automatic hold(input logic md, input gmbh_pkg::core_status_t blk, input logic refuse);
        int k;
        mode_pulse(md, !md);
        @(posedge core_clk);
        core_status <= blk;
        hold_go     <= 1'b1;
        hold_len    <= {1'b1, 3'($random(seed))};
        @(posedge core_clk);
        hold_go <= 1'b0;
        wait_lvl(1, 1'b0, k);
        if (refuse) begin
            `CHK(bus_release_ack_n, 1'b1)
            @(posedge core_clk);
            core_status <= 6'h20;
            wait_lvl(1, 1'b0, k);
        end else `CHK(k >= 15 && k <= 32, 1'b1)
        `CHK(bus_release_ack_n, 1'b0)
        `CHK(addr_oe_n & data_oe_n & strobe_oe_n, 1'b1)
        `CHK(core_halt, md | blk.exec_external)
        `CHK(irq_blocked, md)
        @(posedge core_clk);
        data_acc    <= '{req: 1'b1, wr: 1'b0, addr: 16'hFF00, wdata: 16'h0000};
        core_status <= 6'h00;
        #1;
        `CHK(data_space_strobe, 1'b0)
        `CHK(core_halt, md)
        @(posedge core_clk);
        data_acc.req <= 1'b0;
        core_status  <= 6'h02;
        #1;
        `CHK(core_halt, 1'b1)
        @(posedge core_clk);
        core_status <= 6'h01;
        #1;
        `CHK(core_halt, 1'b1)
        @(posedge core_clk);
        core_status <= 6'h20;
        wait_lvl(1, 1'b1, k);
        wait_lvl(2, 1'b0, k);
        `CHK(k >= 8 && k <= 16, 1'b1)
        `CHK(addr_oe_n, 1'b0)
        `CHK(core_halt, 1'b0)
    endtask : hold

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // ********
    // Main sequence and watchdog
    // ********
    initial begin
        int          i;
        int          j;
        logic [7:0]  g;
        logic [15:0] a;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK(bus_release_ack_n, 1'b1)
        `CHK(addr_oe_n, 1'b0)
        acc(1'b0, `ALLOC_ADDR, 16'h0000);
        // Every legal allocation, its boundary and random addresses
        for (i = 0; i < 10; i++) begin
            g = (i == 0) ? 8'h00 : (i == 1) ? 8'h03 : 8'hFF << (9 - i);
            acc(1'b1, `ALLOC_ADDR, {8'($random(seed)), g});
            acc(1'b0, `ALLOC_ADDR, 16'h0000);
            for (j = 0; j < 6; j++) begin
                a = (j == 0) ? {g, 8'h00} : (j == 1) ? {g, 8'h00} - 16'h0001 : 16'($random(seed));
                acc(1'b0, a, 16'h0000);
            end
        end
        mode_pulse(1'b0, 1'b1);
        mode_pulse(1'b1, 1'b0);
        mode_pulse(1'b1, 1'b1);
        hold(1'b1, 6'h20, 1'b0);
        hold(1'b1, 6'h1C, 1'b1);
        hold(1'b1, 6'h00, 1'b1);
        hold(1'b0, 6'h1C, 1'b0);
        results();
    end

    // A hang ends the run as a failure
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        results();
    end
endmodule : test_global_memory_and_bus_hold
